// ==== rtl/input_enable_secondary_fault_status_led_regs.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - disabled channel: no current, data bit zero
// - channel one is bit zero, ascending
// - bad clock count rejects command, sets flag
// - thermal shutdown flags, kills inputs and leds; gpo mode pins stay driven
// - input reference open or thermal flags bit3
// - input reference short flags, disables channels
// - wirebreak reference open, thermal, none enabled
// - wirebreak reference short flags, no action
// - flags latch until status register read
// - summary needs matching enable bit set
// - led bits row-major, row0col0 to row2col1
// - rows scanned, one third duty each
// - summary read-clear only when nothing enabled set
// - all wirebreak enables low sets open flag
// - led register drives pins only in led mode
module input_enable_secondary_fault_status_led_regs
  import secondary_fault_status_regs_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter int ROW_CYCLES = LED_ROW_CYCLES
)
(
  input wire logic i_clk, // device clock, 40 MHz
  input wire logic i_rst, // sync reset, active high
  input wire logic i_sclk_pulse, // one pulse per serial clock
  input wire logic i_frame_end, // frame ends, command taken now
  input wire logic i_cmd_wr, // command is a write
  input wire logic i_cmd_rd, // command is a read
  input wire logic [ADDR_W-1:0] i_cmd_addr, // register address
  input wire logic [DATA_W-1:0] i_cmd_wdata, // write data
  input wire logic i_primary_rd, // primary fault register read pulse
  input wire logic [CHANNELS-1:0] i_field_data, // filtered field inputs
  input wire logic [CHANNELS-1:0] i_wbe, // wirebreak_detect_enable per channel
  input wire logic i_thermal_shdn, // overtemperature shutdown level
  input wire logic i_in_ref_open, // input_reference_pin open
  input wire logic i_in_ref_short, // input_reference_pin shorted
  input wire logic i_wb_ref_open, // wirebreak_reference_pin open
  input wire logic i_wb_ref_short, // wirebreak_reference_pin shorted
  input wire logic i_supply_ok, // field supply above supply_missing_threshold
  input wire logic i_gpo_dir, // 1: matrix pins are general outputs
  input wire logic [GPO_W-1:0] i_gpo_bits, // general output levels rows 2..0, cols 2..0
  output logic [DATA_W-1:0] o_rdata, // read data
  output logic o_rdata_valid, // read data pulse
  output logic [CHANNELS-1:0] o_current_en, // input current source on
  output logic [CHANNELS-1:0] o_input_data, // input data bits
  output logic o_secondary_fault_status_summary, // summary bit of primary fault register
  output logic [LED_ROWS-1:0] o_led_row, // row drivers, high = on
  output logic [LED_COLS-1:0] o_led_col // column drivers, high = on
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [DATA_W-1:0] input_channel_enable_q;
  logic [DATA_W-1:0] secondary_fault_status_q;
  logic [DATA_W-1:0] secondary_fault_status_d;
  logic [DATA_W-1:0] secondary_fault_enable_q;
  logic [DATA_W-1:0] led_matrix_control_q;
  logic [DATA_W-1:0] fault_set;
  logic [DATA_W-1:0] fault_clr;
  logic frame_bad;
  logic cmd_ok;
  logic wr_ok;
  logic rd_ok;
  logic [1:0] scan_row;
  logic [LED_ROWS*LED_COLS-1:0] led_map;
  logic [CHANNELS-1:0] chan_on;

  function automatic logic masked_any(input logic [DATA_W-1:0] st,
                                      input logic [DATA_W-1:0] en);
    masked_any = |(st & en & SECONDARY_FAULT_STATUS_USED_MASK);
  endfunction

  frame_bit_check u_frame_bit_check (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_sclk_pulse(i_sclk_pulse),
    .i_frame_end(i_frame_end),
    .o_frame_bad(frame_bad)
  );

  led_row_scan #(
    .ROW_CYCLES(ROW_CYCLES)
  ) u_led_row_scan (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .o_row(scan_row)
  );

  assign cmd_ok = i_frame_end && !frame_bad;
  assign wr_ok = cmd_ok && i_cmd_wr;
  assign rd_ok = cmd_ok && i_cmd_rd;

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      input_channel_enable_q <= RST_INPUT_CHANNEL_ENABLE;
    end else if (wr_ok && i_cmd_addr == ADDR_INPUT_CHANNEL_ENABLE) begin
      input_channel_enable_q <= i_cmd_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      secondary_fault_enable_q <= RST_SECONDARY_FAULT_ENABLE;
    end else if (wr_ok && i_cmd_addr == ADDR_SECONDARY_FAULT_ENABLE) begin
      secondary_fault_enable_q <= i_cmd_wdata & SECONDARY_FAULT_STATUS_USED_MASK;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      led_matrix_control_q <= RST_LED_MATRIX_CONTROL;
    end else if (wr_ok && i_cmd_addr == ADDR_LED_MATRIX_CONTROL) begin
      led_matrix_control_q <= i_cmd_wdata;
    end
  end

  // ----------------------------------------
  // secondary fault flags
  // ----------------------------------------
  always_comb begin
    fault_set = '0;
    fault_set[BIT_CLOCK_COUNT_ERROR] = frame_bad;
    fault_set[BIT_THERMAL_SHUTDOWN] = i_thermal_shdn;
    fault_set[BIT_INPUT_REF_OPEN] = i_in_ref_open || i_thermal_shdn;
    fault_set[BIT_INPUT_REF_SHORT] = i_in_ref_short;
    fault_set[BIT_WIREBREAK_REF_OPEN] = i_wb_ref_open || i_thermal_shdn || !(|i_wbe);
    fault_set[BIT_WIREBREAK_REF_SHORT] = i_wb_ref_short;
  end

  // a read returns the old value; a fault still present at the read stays set
  assign fault_clr = (rd_ok && i_cmd_addr == ADDR_SECONDARY_FAULT_STATUS) ? 8'hFF : 8'h00;

  // latch, clear on read, set wins
  assign secondary_fault_status_d =
    ((secondary_fault_status_q & ~fault_clr) | fault_set) & SECONDARY_FAULT_STATUS_USED_MASK;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      secondary_fault_status_q <= RST_SECONDARY_FAULT_STATUS;
    end else begin
      secondary_fault_status_q <= secondary_fault_status_d;
    end
  end

  // summary sticks until read with nothing enabled set
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_secondary_fault_status_summary <= 1'b0;
    end else if (masked_any(secondary_fault_status_q, secondary_fault_enable_q)) begin
      o_secondary_fault_status_summary <= 1'b1;
    end else if (i_primary_rd) begin
      o_secondary_fault_status_summary <= 1'b0;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  // reserved bits read zero through the used mask
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= READ_ZERO;
      o_rdata_valid <= 1'b0;
    end else begin
      o_rdata_valid <= rd_ok;
      if (rd_ok) begin
        unique case (i_cmd_addr)
          ADDR_INPUT_CHANNEL_ENABLE: o_rdata <= input_channel_enable_q;
          ADDR_SECONDARY_FAULT_STATUS: o_rdata <= secondary_fault_status_q;
          ADDR_SECONDARY_FAULT_ENABLE: o_rdata <= secondary_fault_enable_q;
          ADDR_LED_MATRIX_CONTROL: o_rdata <= led_matrix_control_q;
          default: o_rdata <= READ_ZERO;
        endcase
      end
    end
  end

  // ----------------------------------------
  // input channels
  // ----------------------------------------
  // bit i gates channel i+1
  assign chan_on = input_channel_enable_q[CHANNELS-1:0]
                   & {CHANNELS{!i_in_ref_short && !i_thermal_shdn}};

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_current_en <= '0;
      o_input_data <= '0;
    end else begin
      o_current_en <= chan_on;
      o_input_data <= i_field_data & chan_on;
    end
  end

  // ----------------------------------------
  // led matrix
  // ----------------------------------------
  // bit index is row*3+col, last spot is supply status
  assign led_map = {i_supply_ok, led_matrix_control_q};

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_led_row <= '0;
      o_led_col <= '0;
    end else if (i_gpo_dir) begin
      // general output mode; limitation: thermal does not gate these
      o_led_row <= i_gpo_bits[GPO_W-1:LED_COLS];
      o_led_col <= i_gpo_bits[LED_COLS-1:0];
    end else if (i_thermal_shdn) begin
      o_led_row <= '0;
      o_led_col <= '0;
    end else begin
      // one row lit at a time
      o_led_row <= LED_ROWS'(1) << scan_row;
      for (int c = 0; c < LED_COLS; c++) begin
        o_led_col[c] <= led_map[int'(scan_row) * LED_COLS + c];
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  bad_frame_flag_a: assert property (i_frame_end && frame_bad |=>
    secondary_fault_status_q[BIT_CLOCK_COUNT_ERROR] && !o_rdata_valid)
    else $error("bad frame not flagged or not rejected");
  thermal_off_a: assert property (i_thermal_shdn && !i_gpo_dir |=>
    o_current_en == '0 && o_led_row == '0 && secondary_fault_status_q[BIT_THERMAL_SHUTDOWN])
    else $error("thermal shutdown left drivers on");
  chan_disable_a: assert property (!input_channel_enable_q[0] |=>
    !o_current_en[0] && !o_input_data[0])
    else $error("disabled channel still active");
  short_disable_a: assert property (i_in_ref_short |=>
    o_current_en == '0 && secondary_fault_status_q[BIT_INPUT_REF_SHORT])
    else $error("reference short did not disable inputs");
  flag_latch_a: assert property ($fell(i_wb_ref_short) &&
    !(rd_ok && i_cmd_addr == ADDR_SECONDARY_FAULT_STATUS) |=>
    secondary_fault_status_q[BIT_WIREBREAK_REF_SHORT])
    else $error("flag dropped without read");
  status_clear_a: assert property (rd_ok && i_cmd_addr == ADDR_SECONDARY_FAULT_STATUS
    && fault_set == '0 |=> secondary_fault_status_q == '0 ##0
    o_rdata == $past(secondary_fault_status_q))
    else $error("status read did not return and clear");
  summary_set_a: assert property (masked_any(secondary_fault_status_q,
    secondary_fault_enable_q) |=> o_secondary_fault_status_summary)
    else $error("summary not set");
  summary_hold_a: assert property (!o_secondary_fault_status_summary && $past(!o_secondary_fault_status_summary) |->
    !$past(masked_any(secondary_fault_status_q, secondary_fault_enable_q)))
    else $error("summary missed a set");
  no_wbe_open_a: assert property (i_wbe == '0 |=>
    secondary_fault_status_q[BIT_WIREBREAK_REF_OPEN])
    else $error("no wirebreak enable but open flag clear");
  reserved_zero_a: assert property (secondary_fault_status_q[7:6] == 2'h0
    && secondary_fault_enable_q[7:6] == 2'h0)
    else $error("reserved bits set");
  gpo_mode_a: assert property (i_gpo_dir |=>
    {o_led_row, o_led_col} == $past(i_gpo_bits))
    else $error("gpo mode not followed");
  one_row_a: assert property (!i_gpo_dir |=> $onehot0(o_led_row))
    else $error("more than one row lit");

  // faults that must leave the channels alone, thermal flags, the sticky summary, the supply led and reserved enable reads
  fault_keep_a: assert property (!i_in_ref_short && !i_thermal_shdn &&
    (i_in_ref_open || i_wb_ref_open || i_wb_ref_short) |=>
    o_current_en == $past(input_channel_enable_q[CHANNELS-1:0]))
    else $error("reference fault changed the channels");
  thermal_flags_a: assert property (i_thermal_shdn |=>
    secondary_fault_status_q[BIT_INPUT_REF_OPEN] &&
    secondary_fault_status_q[BIT_WIREBREAK_REF_OPEN])
    else $error("thermal shutdown did not flag references");
  summary_keep_a: assert property (o_secondary_fault_status_summary && !i_primary_rd |=>
    o_secondary_fault_status_summary)
    else $error("summary dropped without a read");
  supply_led_a: assert property (!i_gpo_dir && !i_thermal_shdn &&
    scan_row == 2'(LED_ROWS - 1) |=> o_led_col[LED_COLS-1] == $past(i_supply_ok))
    else $error("supply led wrong");
  reserved_read_a: assert property (rd_ok &&
    i_cmd_addr == ADDR_SECONDARY_FAULT_ENABLE |=> o_rdata[7:6] == 2'h0)
    else $error("reserved enable bits read back");

  read_cov: cover property (rd_ok && i_cmd_addr == ADDR_SECONDARY_FAULT_STATUS);
  bad_frame_cov: cover property (i_frame_end && frame_bad && i_cmd_wr);
  summary_cov: cover property (o_secondary_fault_status_summary ##1 !o_secondary_fault_status_summary);
  row_two_cov: cover property (o_led_row[2] && o_led_col[2]);
endmodule

// ==== rtl/secondary_fault_status_regs_pkg.sv ====
package secondary_fault_status_regs_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] ADDR_INPUT_CHANNEL_ENABLE = 8'h1A;
  localparam logic [7:0] ADDR_SECONDARY_FAULT_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_SECONDARY_FAULT_ENABLE = 8'h1E;
  localparam logic [7:0] ADDR_LED_MATRIX_CONTROL = 8'h20;
  localparam logic [7:0] RST_INPUT_CHANNEL_ENABLE = 8'hFF;
  localparam logic [7:0] RST_SECONDARY_FAULT_STATUS = 8'h02;
  localparam logic [7:0] RST_SECONDARY_FAULT_ENABLE = 8'h00;
  localparam logic [7:0] RST_LED_MATRIX_CONTROL = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // ----------------------------------------
  // secondary fault bit positions
  // ----------------------------------------
  localparam int BIT_CLOCK_COUNT_ERROR = 5;
  localparam int BIT_THERMAL_SHUTDOWN = 4;
  localparam int BIT_INPUT_REF_OPEN = 3;
  localparam int BIT_INPUT_REF_SHORT = 2;
  localparam int BIT_WIREBREAK_REF_OPEN = 1;
  localparam int BIT_WIREBREAK_REF_SHORT = 0;
  localparam logic [7:0] SECONDARY_FAULT_STATUS_USED_MASK = 8'h3F;
  // ----------------------------------------
  // framing and led scan
  // ----------------------------------------
  localparam int BITS_PER_BYTE = 8;
  localparam int CLK_FREQ_HZ = 40_000_000;
  localparam int LED_ROW_TIME_US = 100;
  localparam int LED_ROW_CYCLES = CLK_FREQ_HZ / 1_000_000 * LED_ROW_TIME_US;
  localparam int LED_ROWS = 3;
  localparam int LED_COLS = 3;
  localparam int GPO_W = 6;
endpackage

// ==== rtl/frame_bit_check.sv ====
`timescale 1ns/1ps
module frame_bit_check
  import secondary_fault_status_regs_pkg::*;
(
  input wire logic i_clk, // device clock
  input wire logic i_rst, // sync reset, active high
  input wire logic i_sclk_pulse, // one pulse per serial clock edge
  input wire logic i_frame_end, // frame ends this cycle
  output logic o_frame_bad // count not a multiple of eight, valid with i_frame_end
);
  localparam int CNT_W = $clog2(BITS_PER_BYTE);
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;

  // modulo-eight count wraps naturally; only the remainder matters
  always_comb begin
    count_d = count_q + CNT_W'(i_sclk_pulse);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || i_frame_end) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign o_frame_bad = i_frame_end && (count_d != '0);
endmodule

// ==== rtl/led_row_scan.sv ====
`timescale 1ns/1ps
module led_row_scan
  import secondary_fault_status_regs_pkg::*;
#(
  parameter int ROW_CYCLES = LED_ROW_CYCLES
)
(
  input wire logic i_clk, // device clock
  input wire logic i_rst, // sync reset, active high
  output logic [1:0] o_row // row now being driven
);
  localparam int DIV_W = $clog2(ROW_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(ROW_CYCLES - 1);
  localparam logic [1:0] ROW_LAST = 2'(LED_ROWS - 1);
  logic [DIV_W-1:0] div_q;
  logic step;

  assign step = (div_q == DIV_LAST);

  always_ff @(posedge i_clk) begin
    if (i_rst || step) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DIV_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_row <= 2'h0;
    end else if (step) begin
      o_row <= (o_row == ROW_LAST) ? 2'h0 : o_row + 2'h1;
    end
  end
endmodule

// ==== verification/spi_host_model.sv ====
`timescale 1ns/1ps
module spi_host_model (
  input wire logic i_clk, // device clock
  output logic o_sclk_pulse, // one pulse per serial clock
  output logic o_frame_end, // frame closes, command taken
  output logic o_cmd_wr, // command is a write
  output logic o_cmd_rd, // command is a read
  output logic [7:0] o_cmd_addr, // register address
  output logic [7:0] o_cmd_wdata // write data
);
  initial begin
    o_sclk_pulse = 1'b0;
    o_frame_end = 1'b0;
    o_cmd_wr = 1'b0;
    o_cmd_rd = 1'b0;
    o_cmd_addr = 8'h00;
    o_cmd_wdata = 8'h00;
  end

  // ----------------------------------------
  // one frame of nclk serial clocks
  // ----------------------------------------
  // fields are only valid with frame end; afterwards address and data are inverted so
  // that a design sampling them outside the frame sees changing garbage
  task automatic frame(input logic wr, input logic rd, input logic [7:0] addr,
                       input logic [7:0] data, input int nclk);
    for (int i = 0; i < nclk; i++) begin
      @(negedge i_clk);
      o_sclk_pulse = 1'b1;
      if (i == nclk - 1) begin
        o_frame_end = 1'b1;
        o_cmd_wr = wr;
        o_cmd_rd = rd;
        o_cmd_addr = addr;
        o_cmd_wdata = data;
      end
    end
    @(negedge i_clk);
    o_sclk_pulse = 1'b0;
    o_frame_end = 1'b0;
    o_cmd_wr = 1'b0;
    o_cmd_rd = 1'b0;
    o_cmd_addr = ~addr;
    o_cmd_wdata = ~data;
  endtask
endmodule

// ==== verification/input_enable_secondary_fault_status_led_regs_test.sv ====
`timescale 1ns/1ps
module input_enable_secondary_fault_status_led_regs_test
  import secondary_fault_status_regs_pkg::*;
;
  localparam int ROWC = 4;
  localparam logic [7:0] A_EN = ADDR_INPUT_CHANNEL_ENABLE;
  localparam logic [7:0] A_ST = ADDR_SECONDARY_FAULT_STATUS;
  localparam logic [7:0] A_FE = ADDR_SECONDARY_FAULT_ENABLE;
  localparam logic [7:0] A_LED = ADDR_LED_MATRIX_CONTROL;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic sclk, fend, cwr, crd, valid, summary;
  logic [7:0] caddr, cdata, rdata, cur_en, in_data;
  logic primary_rd = 1'b0;
  logic [7:0] field = 8'hFF;
  logic [7:0] wirebreak_detect_enable = 8'hFF;
  // thermal, input ref open, input ref short, wb ref open, wb ref short
  logic [4:0] flt = 5'h00;
  logic supply_ok = 1'b1;
  logic gpo_dir = 1'b0;
  logic [5:0] gpo_bits = 6'h00;
  logic [2:0] row, col;
  logic [7:0] fexp [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h1A};
  int num_errors = 0;
  int n_tests = 0;

  always #12.5 i_clk = ~i_clk;

  spi_host_model host_u (.i_clk(i_clk), .o_sclk_pulse(sclk), .o_frame_end(fend),
    .o_cmd_wr(cwr), .o_cmd_rd(crd), .o_cmd_addr(caddr), .o_cmd_wdata(cdata));

  input_enable_secondary_fault_status_led_regs #(.CHANNELS(8), .ROW_CYCLES(ROWC)) dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_sclk_pulse(sclk), .i_frame_end(fend),
    .i_cmd_wr(cwr), .i_cmd_rd(crd), .i_cmd_addr(caddr), .i_cmd_wdata(cdata),
    .i_primary_rd(primary_rd), .i_field_data(field), .i_wbe(wirebreak_detect_enable),
    .i_thermal_shdn(flt[4]), .i_in_ref_open(flt[3]), .i_in_ref_short(flt[2]),
    .i_wb_ref_open(flt[1]), .i_wb_ref_short(flt[0]), .i_supply_ok(supply_ok),
    .i_gpo_dir(gpo_dir), .i_gpo_bits(gpo_bits), .o_rdata(rdata),
    .o_rdata_valid(valid), .o_current_en(cur_en), .o_input_data(in_data),
    .o_secondary_fault_status_summary(summary), .o_led_row(row), .o_led_col(col));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    host_u.frame(1'b1, 1'b0, a, d, 8);
  endtask

  // the valid pulse stands from the taking edge to the next one, so look at falling edges
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] got;
    got = 8'hXX;
    host_u.frame(1'b0, 1'b1, a, 8'h00, 8);
    for (int k = 0; k < 4; k++) begin
      if (valid === 1'b1) begin
        got = rdata;
        break;
      end
      @(negedge i_clk);
    end
    check(got, exp);
  endtask

  // twelve cycles cover every row the same number of times whatever the phase
  task automatic scan_chk(input logic [8:0] l9);
    int r;
    int hits [3] = '{0, 0, 0};
    cyc(2);
    repeat (3 * ROWC) begin
      @(negedge i_clk);
      r = (row === 3'b001) ? 0 : (row === 3'b010) ? 1 : (row === 3'b100) ? 2 : 3;
      if (r < 3) begin
        hits[r]++;
        check({5'h00, col}, {5'h00, l9[r*3 +: 3]}); // column pattern
      end else begin
        check({5'h00, row}, 8'h01); // single row driven
      end
    end
    for (r = 0; r < 3; r++) begin
      check(hits[r][7:0], 8'(ROWC)); // equal row share
    end
  endtask

  task automatic test_done(input string s);
    $display("test %s done, mismatches so far %0d", s, num_errors);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (16) @(negedge i_clk);
    i_rst = 1'b0;
    rd_chk(A_EN, RST_INPUT_CHANNEL_ENABLE); // enable reset value
    rd_chk(A_ST, RST_SECONDARY_FAULT_STATUS); // open flag after reset
    rd_chk(A_ST, 8'h00); // cleared by read
    rd_chk(A_FE, RST_SECONDARY_FAULT_ENABLE); // mask reset value
    rd_chk(A_LED, RST_LED_MATRIX_CONTROL); // led reset value
    rd_chk(8'h22, 8'h00); // unmapped reads zero
    wr_reg(A_FE, 8'hFF);
    rd_chk(A_FE, 8'h3F); // reserved bits zero
    wr_reg(A_FE, 8'h00);
    wr_reg(A_ST, 8'h3F);
    rd_chk(A_ST, 8'h00); // status write ignored
    test_done("registers");
    for (int ch = 0; ch < 8; ch++) begin
      wr_reg(A_EN, 8'h01 << ch);
      cyc(2);
      check(cur_en, 8'h01 << ch); // channel bit order
      check(in_data, 8'h01 << ch); // data gated
    end
    field = 8'h7F;
    cyc(2);
    check(in_data, 8'h00); // disabled data low
    field = 8'hFF;
    wr_reg(A_EN, 8'hFF);
    test_done("channels");
    for (int b = 0; b < 5; b++) begin
      flt = 5'h01 << b;
      cyc(3);
      check(cur_en, (b == 2 || b == 4) ? 8'h00 : 8'hFF);
      if (b == 4) check({5'h00, row}, 8'h00); // leds off in shutdown
      flt = 5'h00;
      cyc(2);
      rd_chk(A_ST, fexp[b]); // latched
      rd_chk(A_ST, 8'h00); // cleared by read
      check({7'h00, summary}, 8'h00); // masked flags
    end
    wirebreak_detect_enable = 8'h00;
    cyc(2);
    wirebreak_detect_enable = 8'hFF;
    rd_chk(A_ST, 8'h02); // no wirebreak enabled
    test_done("fault flags");
    host_u.frame(1'b1, 1'b0, A_LED, 8'h55, 7);
    rd_chk(A_LED, 8'h00); // short frame write refused
    host_u.frame(1'b0, 1'b1, A_ST, 8'h00, 9);
    check({7'h00, valid}, 8'h00); // long frame read refused
    rd_chk(A_ST, 8'h20); // count error flag
    rd_chk(A_ST, 8'h00); // cleared by read
    test_done("clock count");
    wr_reg(A_FE, 8'h01);
    flt = 5'h01;
    cyc(1);
    flt = 5'h00;
    cyc(2);
    check({7'h00, summary}, 8'h01); // enabled flag sets summary
    primary_rd = 1'b1;
    cyc(1);
    primary_rd = 1'b0;
    cyc(2);
    check({7'h00, summary}, 8'h01); // held while flag set
    rd_chk(A_ST, 8'h01); // short flag latched
    primary_rd = 1'b1;
    cyc(1);
    primary_rd = 1'b0;
    cyc(2);
    check({7'h00, summary}, 8'h00); // clears once status clear
    wr_reg(A_FE, 8'h02);
    flt = 5'h01;
    cyc(3);
    flt = 5'h00;
    check({7'h00, summary}, 8'h00); // other position enabled
    rd_chk(A_ST, 8'h01); // flag latched
    test_done("summary");
    wr_reg(A_LED, 8'hA5);
    scan_chk({1'b1, 8'hA5});
    supply_ok = 1'b0;
    wr_reg(A_LED, 8'h5A);
    scan_chk({1'b0, 8'h5A});
    gpo_dir = 1'b1;
    gpo_bits = 6'h29;
    cyc(2);
    check({2'h0, row, col}, 8'h29); // pins follow general outputs
    gpo_dir = 1'b0;
    test_done("leds");
    final_report;
  end

  // a full run needs well under two thousand cycles
  initial begin
    #(20000 * 25);
    num_errors++;
    $display("BAD t=%0t watchdog expired", $time);
    final_report;
  end
endmodule
